/* design/poe_port_host_control.sv */
// host-side control: serial slave, event output, shutdowns, port timers
//
// What this block does
// - chip reset holds ports off, registers default
// - chip reset ignores lows under 1us
// - unmasked event pulls event output low
// - pushbutton bit 6 or 7 releases event
// - event mask register gates each source
// - event output changes only with bus idle
// - fault during transfer waits for stop
// - separate data sense pin, open-drain drive
// - slave address 010 plus four straps
// - port shutdown pin turns port off
// - port shutdown ignores lows under 1us
// - masked shutdown resets ports selected in 17h
// - defaults follow standalone strap, stay writable
// - live standalone strap in pin status bit 0
// - midspan strap high latched into mode register bit 1
// - mode straps latched only at reset
// - fault timer runs while current over threshold
// - timer expiry drops drive, records timeout event
// - power good set when port voltage low
// - reset-all bit equals chip reset
`timescale 1ns/1ps
`default_nettype none
`include "poe_port_map.svh"
module poe_port_host_control #(
  parameter int PORTS = 4,
  parameter int FAULT_CYCLES = `FAULT_CYCLES
) (
  input wire logic ref_clk_i, // 20 MHz system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic chip_reset_n_i, // chip reset pin, active low
  input wire logic serial_clock_i, // serial bus clock pin
  input wire logic serial_data_sense_i, // serial data input pin
  output logic serial_data_drive_o, // data drive level, always low
  output logic serial_data_drive_oe_o, // high pulls data line low
  input wire logic addr_strap_3_i, // address strap bit 3
  input wire logic addr_strap_2_i, // address strap bit 2
  input wire logic addr_strap_1_i, // address strap bit 1
  input wire logic addr_strap_0_i, // address strap bit 0
  input wire logic [PORTS-1:0] port_off_n_i, // per-port shutdown, low
  input wire logic masked_port_off_n_i, // maskable shutdown, low
  input wire logic standalone_strap_i, // standalone mode strap
  input wire logic midspan_strap_i, // midspan mode strap
  input wire logic [PORTS-1:0] current_sense_in_i, // over threshold
  input wire logic [PORTS-1:0] port_voltage_monitor_i, // below 2.4 V
  output logic [PORTS-1:0] fet_drive_o, // transistor gate drive
  output logic event_out_o, // event pin level, always low
  output logic event_oe_o // high pulls event pin low
);
  localparam int NF = PORTS + 2;
  localparam int NS = 3 * PORTS + 9;

  logic scl, sda, chip_n, msd_n, auto_s, mid_s;
  logic [3:0] straps;
  logic [PORTS-1:0] off_n, over, volt_low;
  logic [NS-1:0] synced;
  logic [NF-1:0] filt;
  logic chip_f, msd_f;
  logic [PORTS-1:0] off_f;

  // all pins are asynchronous to the system clock
  pin_sync #(.WIDTH(NS), .RESET_VAL({{2{1'b1}}, {PORTS{1'b1}},
    1'b1, 2'b00, 4'hf, {2*PORTS{1'b0}}})) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({serial_clock_i, serial_data_sense_i, port_off_n_i,
      masked_port_off_n_i, standalone_strap_i, midspan_strap_i,
      addr_strap_3_i, addr_strap_2_i, addr_strap_1_i, addr_strap_0_i,
      current_sense_in_i, port_voltage_monitor_i}),
    .sync_o(synced)
  );
  assign {scl, sda, off_n, msd_n, auto_s, mid_s, straps, over,
    volt_low} = synced;

  // chip reset has its own sync; it also goes through the filter
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_rst (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(chip_reset_n_i),
    .sync_o(chip_n)
  );

  // one glitch filter per shutdown-type line: ports, masked, chip
  logic [NF-1:0] filt_in;
  assign filt_in = {chip_n, msd_n, off_n};
  for (genvar g = 0; g < NF; g++) begin : g_filt
    low_glitch_filter #(.CYCLES(`FILTER_CYCLES)) u_filt (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .level_i(filt_in[g]),
      .level_o(filt[g])
    );
  end
  assign off_f = filt[PORTS-1:0];
  assign msd_f = filt[PORTS];
  assign chip_f = filt[PORTS+1];

  // ---- reset, straps and defaults ----
  logic reset_all_req, soft_rst, load_defaults;
  logic [1:0] settle;
  logic auto_mode, mid_mode;
  assign soft_rst = !chip_f || reset_all_req;
  assign load_defaults = soft_rst || (settle != `SETTLE_DONE);

  // waits for the synchroniser to fill before trusting strap levels
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle <= 2'h0;
    end else if (settle != `SETTLE_DONE) begin
      settle <= settle + 2'h1;
    end
  end

  // straps are caught only while in reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_mode <= 1'b0;
      mid_mode <= 1'b0;
    end else if (load_defaults) begin
      auto_mode <= auto_s;
      mid_mode <= mid_s;
    end
  end

  // ---- serial slave ----
  poe_port_pkg::bus_state_type state;
  logic scl_q, sda_q, rise, fall, start_c, stop_c, busy, rw, nack;
  logic [3:0] bit_cnt;
  logic [7:0] shift, ptr, tx;
  logic wr_stb;
  logic [7:0] wr_addr, wr_data;
  logic [6:0] dev_addr;
  assign dev_addr = {`ADDR_HIGH_BITS, straps};
  assign rise = scl && !scl_q;
  assign fall = !scl && scl_q;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c = scl && scl_q && !sda_q && sda;

  // combinational register read multiplexer
  logic [7:0] event_status, event_mask, misc_cfg;
  logic [PORTS-1:0] power_on, power_good;
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `REG_EVENT_STATUS: r = event_status;
      `REG_EVENT_MASK: r = event_mask;
      `REG_PORT_STATUS: r = 8'({fet_drive_o, power_good});
      `REG_PIN_STATUS: r = {7'h00, auto_s};
      `REG_MODE_LATCH: r = {6'h00, mid_mode, auto_mode};
      `REG_MISC_CONFIG: r = misc_cfg;
      `REG_POWER_ON: r = 8'(power_on);
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // byte that a read phase will send next; follows every register
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = read_reg(ptr);
  end

  // edge history of the sampled bus lines
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // byte engine: sample on clock rise, drive on clock fall
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= poe_port_pkg::st_idle;
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      serial_data_drive_oe_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state <= poe_port_pkg::st_addr;
        busy <= 1'b1;
        bit_cnt <= 4'h0;
        serial_data_drive_oe_o <= 1'b0;
      end else if (stop_c || soft_rst) begin
        state <= poe_port_pkg::st_idle;
        busy <= 1'b0;
        serial_data_drive_oe_o <= 1'b0;
      end else begin
        unique case (state)
          poe_port_pkg::st_idle: begin
          end
          poe_port_pkg::st_addr, poe_port_pkg::st_ptr,
          poe_port_pkg::st_wdata: begin
            if (rise) begin
              shift <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (fall && bit_cnt == `BYTE_BITS) begin
              bit_cnt <= 4'h0;
              serial_data_drive_oe_o <= 1'b1;
              if (state == poe_port_pkg::st_addr) begin
                if (shift[7:1] == dev_addr) begin
                  rw <= shift[0];
                  state <= poe_port_pkg::st_addr_ack;
                end else begin
                  serial_data_drive_oe_o <= 1'b0;
                  state <= poe_port_pkg::st_idle;
                end
              end else if (state == poe_port_pkg::st_ptr) begin
                ptr <= shift;
                state <= poe_port_pkg::st_ptr_ack;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shift;
                state <= poe_port_pkg::st_wdata_ack;
              end
            end
          end
          poe_port_pkg::st_addr_ack, poe_port_pkg::st_ptr_ack,
          poe_port_pkg::st_wdata_ack: begin
            if (fall) begin
              if (state == poe_port_pkg::st_addr_ack && rw) begin
                tx <= {rd_byte[6:0], 1'b0};
                serial_data_drive_oe_o <= !rd_byte[7];
                bit_cnt <= 4'h1;
                state <= poe_port_pkg::st_rdata;
              end else begin
                serial_data_drive_oe_o <= 1'b0;
                if (state == poe_port_pkg::st_wdata_ack) begin
                  ptr <= ptr + 8'h01;
                end
                state <= (state == poe_port_pkg::st_addr_ack) ?
                  poe_port_pkg::st_ptr : poe_port_pkg::st_wdata;
              end
            end
          end
          poe_port_pkg::st_rdata: begin
            if (fall && bit_cnt == `BYTE_BITS) begin
              serial_data_drive_oe_o <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= poe_port_pkg::st_rack;
            end else if (fall) begin
              serial_data_drive_oe_o <= !tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          poe_port_pkg::st_rack: begin
            if (rise) begin
              nack <= sda;
            end else if (fall && nack) begin
              state <= poe_port_pkg::st_idle;
            end else if (fall) begin
              tx <= {rd_byte[6:0], 1'b0};
              serial_data_drive_oe_o <= !rd_byte[7];
              bit_cnt <= 4'h1;
              state <= poe_port_pkg::st_rdata;
            end
          end
        endcase
      end
    end
  end

  // ---- writable registers ----
  logic pb_wr, release_req, clear_req;
  logic [PORTS-1:0] pb_port_off;
  assign pb_wr = wr_stb && wr_addr == `REG_PUSHBUTTON;
  assign release_req = pb_wr && (wr_data[`PB_RELEASE_BIT] ||
    wr_data[`PB_CLEAR_BIT]);
  assign clear_req = pb_wr && wr_data[`PB_CLEAR_BIT];
  assign pb_port_off = pb_wr ? wr_data[PORTS-1:0] : '0;

  // mask and shutdown-select registers, defaults on every reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_mask <= `EVENT_MASK_RESET;
      misc_cfg <= `MISC_CONFIG_RESET;
      reset_all_req <= 1'b0;
    end else begin
      reset_all_req <= pb_wr && wr_data[`PB_RESET_ALL_BIT];
      if (load_defaults) begin
        event_mask <= `EVENT_MASK_RESET;
        misc_cfg <= `MISC_CONFIG_RESET;
      end else if (wr_stb && wr_addr == `REG_EVENT_MASK) begin
        event_mask <= wr_data;
      end else if (wr_stb && wr_addr == `REG_MISC_CONFIG) begin
        misc_cfg <= wr_data;
      end
    end
  end

  // ---- ports: shutdown, fault timer, power good ----
  logic [PORTS-1:0] kill, expire, starting;
  logic [PORTS-1:0] ev_cut, ev_start;
  logic [31:0] fault_cnt [PORTS];
  assign kill = ~off_f | (misc_cfg[PORTS-1:0] & {PORTS{!msd_f}}) |
    pb_port_off;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    assign expire[p] = fault_cnt[p] == 32'(FAULT_CYCLES - 1);

    // fault timer runs only while the drive is on and current is high
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fault_cnt[p] <= 32'h0000_0000;
      end else if (!fet_drive_o[p] || !over[p] || expire[p]) begin
        fault_cnt[p] <= 32'h0000_0000;
      end else begin
        fault_cnt[p] <= fault_cnt[p] + 32'h0000_0001;
      end
    end

    // start-up window lasts from turn-on until power good
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        starting[p] <= 1'b0;
      end else if (!fet_drive_o[p]) begin
        starting[p] <= 1'b1;
      end else if (power_good[p]) begin
        starting[p] <= 1'b0;
      end
    end
  end
  assign ev_cut = expire & ~starting;
  assign ev_start = expire & starting;

  // power requests: default from the standalone strap, host writable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_on <= '0;
    end else if (load_defaults) begin
      power_on <= auto_s ? PORTS'(`POWER_ON_AUTO) :
        PORTS'(`POWER_ON_HOST);
    end else if (wr_stb && wr_addr == `REG_POWER_ON) begin
      power_on <= wr_data[PORTS-1:0] & ~kill & ~expire;
    end else begin
      power_on <= power_on & ~kill & ~expire;
    end
  end

  // gate drive and power good straight from flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fet_drive_o <= '0;
      power_good <= '0;
    end else begin
      fet_drive_o <= soft_rst ? '0 : (power_on & ~kill & ~expire);
      power_good <= volt_low & fet_drive_o;
    end
  end

  // ---- events and event pin ----
  logic [7:0] new_ev;
  logic int_flag;
  assign new_ev = 8'({ev_start, ev_cut});

  // sticky event bits; a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_status <= 8'h00;
      int_flag <= 1'b0;
    end else if (soft_rst) begin
      event_status <= 8'h00;
      int_flag <= 1'b0;
    end else begin
      event_status <= (clear_req ? 8'h00 : event_status) | new_ev;
      if ((new_ev & event_mask) != 8'h00) begin
        int_flag <= 1'b1;
      end else if (release_req) begin
        int_flag <= 1'b0;
      end
    end
  end

  // pin follows the flag only between transfers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_oe_o <= 1'b0;
      event_out_o <= 1'b0;
      serial_data_drive_o <= 1'b0;
    end else if (!busy) begin
      event_oe_o <= int_flag;
    end
  end

  reset_ports_off_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) soft_rst |=> fet_drive_o == '0)
    else $error("port powered during reset");
  event_release_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    release_req && (new_ev & event_mask) == 8'h00 && !soft_rst
    |=> !int_flag ##1 (busy || !event_oe_o))
    else $error("event not released by pushbutton write");
  mask_gate_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    $rose(int_flag) |-> $past((new_ev & event_mask) != 8'h00))
    else $error("masked source raised the event");
  bus_idle_update_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) busy |=> $stable(event_oe_o))
    else $error("event pin moved during a transfer");
  address_match_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    $rose(state == poe_port_pkg::st_addr_ack)
    |-> $past(shift[7:1]) == dev_addr && serial_data_drive_oe_o)
    else $error("acknowledged a foreign address");
  shutdown_off_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    kill != '0 |=> (fet_drive_o & $past(kill)) == '0)
    else $error("port left on under shutdown");
  fault_expiry_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) expire != '0 && !soft_rst && !clear_req
    |=> (fet_drive_o & $past(expire)) == '0 && event_status != 8'h00)
    else $error("timer expiry did not drop drive");
  strap_hold_a: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !load_defaults |=> $stable(auto_mode)
    && $stable(mid_mode))
    else $error("strap mode changed outside reset");
  event_cover_c: cover property (@(posedge ref_clk_i) $rose(event_oe_o));
  write_cover_c: cover property (@(posedge ref_clk_i) wr_stb);
  read_cover_c: cover property (@(posedge ref_clk_i)
    state == poe_port_pkg::st_rack);
endmodule
`default_nettype wire

/* design/poe_port_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef POE_PORT_MAP_SVH
`define POE_PORT_MAP_SVH
`define REG_EVENT_STATUS 8'h00
`define REG_EVENT_MASK 8'h01
`define REG_PORT_STATUS 8'h10
`define REG_PIN_STATUS 8'h11
`define REG_MODE_LATCH 8'h12
`define REG_MISC_CONFIG 8'h17
`define REG_POWER_ON 8'h19
`define REG_PUSHBUTTON 8'h1a
`define ADDR_HIGH_BITS 3'h2
`define PB_RESET_ALL_BIT 4
`define PB_RELEASE_BIT 6
`define PB_CLEAR_BIT 7
`define EVENT_MASK_RESET 8'h00
`define MISC_CONFIG_RESET 8'h00
`define POWER_ON_AUTO 4'hf
`define POWER_ON_HOST 4'h0
`define BYTE_BITS 4'h8
`define SETTLE_DONE 2'h3
`define CLK_PERIOD_NS 50
`define FILTER_TIME_NS 1000
`define FILTER_CYCLES ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_TIME_US 62500
`define FAULT_CYCLES ((`FAULT_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

/* design/poe_port_pkg.sv */
// types shared by the port controller host-side logic
package poe_port_pkg;
  typedef enum {
    st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rack
  } bus_state_type;
endpackage

/* design/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [WIDTH-1:0] async_i, // raw pins
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] first;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      first <= async_i;
      sync_o <= first;
    end
  end
endmodule
`default_nettype wire

/* design/low_glitch_filter.sv */
// rejects low pulses shorter than the filter time on one line
`timescale 1ns/1ps
`default_nettype none
`include "poe_port_map.svh"
module low_glitch_filter #(
  parameter int CYCLES = `FILTER_CYCLES
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic level_i, // synchronised input
  output logic level_o // filtered level, idle high
);
  logic [15:0] low_cnt;

  // output drops only after the input stayed low for the full time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 16'h0000;
      level_o <= 1'b1;
    end else if (level_i) begin
      low_cnt <= 16'h0000;
      level_o <= 1'b1;
    end else if (low_cnt == 16'(CYCLES - 1)) begin
      level_o <= 1'b0;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  glitch_reject_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(level_o) |-> $past(low_cnt) == 16'(CYCLES - 1))
    else $error("filter output fell before the filter time");
endmodule
`default_nettype wire

/* verif/serial_host_model.sv */
// serial bus host model: byte transfers and register accesses
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic ref_clk_i, // system clock, paces the serial clock
  input wire logic sda_i, // resolved data line level
  output logic scl_o, // serial clock, stands high outside frames
  output logic sda_pull_o // high pulls the data line low
);
  // half a serial clock period: 4 system cycles, 200 ns
  task automatic half();
    repeat (4) @(negedge ref_clk_i);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask
  // stop: data rises while clock is high, clock then stands high
  task automatic stop();
    sda_pull_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_pull_o = 1'b0;
    half();
  endtask
  // eight bits msb first, then the ack slot; mack pulls ack low
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o = ~tx[i];
      half();
      scl_o = 1'b1;
      half();
      rx[i] = sda_i;
      scl_o = 1'b0;
    end
    sda_pull_o = mack;
    half();
    scl_o = 1'b1;
    half();
    ack = sda_i;
    scl_o = 1'b0;
  endtask
  // register write; ack returns the address-phase acknowledge level
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ack);
    logic [7:0] rx;
    logic a;
    start();
    xfer({dev, 1'b0}, 1'b0, rx, ack);
    if (ack === 1'b0) begin
      xfer(ptr, 1'b0, rx, a);
      xfer(data, 1'b0, rx, a);
    end
    stop();
  endtask
  // register read through pointer write and repeated start
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data);
    logic [7:0] rx;
    logic a;
    start();
    xfer({dev, 1'b0}, 1'b0, rx, a);
    xfer(ptr, 1'b0, rx, a);
    start();
    xfer({dev, 1'b1}, 1'b0, rx, a);
    xfer(8'hff, 1'b0, data, a);
    stop();
  endtask
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
endmodule
`default_nettype wire

/* verif/poe_port_host_control_tb_top.sv */
// self-checking bench for the port controller host-side logic
`timescale 1ns/1ps
`default_nettype none
`include "poe_port_map.svh"
module poe_port_host_control_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic chip_reset_n_i = 1'b1;
  logic masked_port_off_n_i = 1'b1;
  logic standalone_strap_i = 1'b1;
  logic midspan_strap_i = 1'b0;
  logic [3:0] straps = 4'hf;
  logic [3:0] port_off_n_i = 4'hf;
  logic [3:0] current_sense_in_i = 4'h0;
  logic [3:0] port_voltage_monitor_i = 4'h0;
  logic [3:0] fet_drive_o;
  logic scl, host_pull, sda_drive, sda_oe, event_out_o, event_oe_o, ack;
  logic [7:0] rd;
  logic [6:0] dev;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int mask_m;
  int on_m;
  // data line with pull-up: low when either party pulls it
  wire logic sda = ~(host_pull | sda_oe);
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  poe_port_host_control #(.PORTS(4), .FAULT_CYCLES(50)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .chip_reset_n_i(chip_reset_n_i), .serial_clock_i(scl),
    .serial_data_sense_i(sda), .serial_data_drive_o(sda_drive),
    .serial_data_drive_oe_o(sda_oe), .addr_strap_3_i(straps[3]),
    .addr_strap_2_i(straps[2]), .addr_strap_1_i(straps[1]),
    .addr_strap_0_i(straps[0]), .port_off_n_i(port_off_n_i),
    .masked_port_off_n_i(masked_port_off_n_i),
    .standalone_strap_i(standalone_strap_i),
    .midspan_strap_i(midspan_strap_i),
    .current_sense_in_i(current_sense_in_i),
    .port_voltage_monitor_i(port_voltage_monitor_i),
    .fet_drive_o(fet_drive_o), .event_out_o(event_out_o),
    .event_oe_o(event_oe_o));
  serial_host_model u_host (.ref_clk_i(ref_clk_i), .sda_i(sda),
    .scl_o(scl), .sda_pull_o(host_pull));
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h037e69a9));
    straps = 4'($urandom());
    dev = {`ADDR_HIGH_BITS, straps};
    cyc(20);
    rst_n_i = 1'b1;
    cyc(10);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("mask reset", rd, `EVENT_MASK_RESET);
    u_host.read_reg(dev, `REG_POWER_ON, rd);
    check("power default", rd, 8'(`POWER_ON_AUTO));
    check("pin levels", {6'h00, sda_drive, event_out_o}, 8'h00);
    mask_m = 8'($urandom());
    u_host.write_reg(dev, `REG_EVENT_MASK, 8'(mask_m), ack);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("mask rw", rd, 8'(mask_m));
    u_host.write_reg({dev[6:1], ~dev[0]}, `REG_EVENT_MASK, 8'h00, ack);
    check("foreign nack", {7'h0, ack}, 8'h01);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("mask kept", rd, 8'(mask_m));
    // live standalone strap, both levels
    for (int s = 1; s >= 0; s--) begin
      standalone_strap_i = 1'(s);
      cyc(5);
      u_host.read_reg(dev, `REG_PIN_STATUS, rd);
      check("strap live", {7'h0, rd[0]}, 8'(s));
      u_host.read_reg(dev, `REG_MODE_LATCH, rd);
      check("strap latched", rd, 8'h01);
    end
    standalone_strap_i = 1'b1;
    on_m = 4'hf;
    u_host.write_reg(dev, `REG_POWER_ON, 8'(on_m), ack);
    cyc(3);
    check("ports on", 8'(fet_drive_o), 8'(on_m));
    // short low on port 1 shutdown is ignored, long one kills it
    port_off_n_i[1] = 1'b0;
    cyc(10);
    port_off_n_i[1] = 1'b1;
    cyc(30);
    check("glitch", 8'(fet_drive_o), 8'(on_m));
    port_off_n_i[1] = 1'b0;
    cyc(40);
    port_off_n_i[1] = 1'b1;
    on_m = on_m & ~4'h2;
    check("port off", 8'(fet_drive_o), 8'(on_m));
    // masked shutdown selects port 2 only
    u_host.write_reg(dev, `REG_MISC_CONFIG, 8'h04, ack);
    masked_port_off_n_i = 1'b0;
    cyc(40);
    masked_port_off_n_i = 1'b1;
    on_m = on_m & ~4'h4;
    check("masked off", 8'(fet_drive_o), 8'(on_m));
    // overcurrent on ports 0 and 3 with events enabled
    mask_m = 8'hff;
    u_host.write_reg(dev, `REG_EVENT_MASK, 8'(mask_m), ack);
    // port 0 reaches power good, port 3 never does
    port_voltage_monitor_i = 4'h1;
    cyc(5);
    u_host.read_reg(dev, `REG_PORT_STATUS, rd);
    check("power good", rd, {4'(on_m), 4'h1});
    current_sense_in_i = 4'h9;
    cyc(40);
    check("timer runs", 8'(fet_drive_o), 8'(on_m));
    check("no event yet", {7'h0, event_oe_o}, 8'h00);
    cyc(20);
    current_sense_in_i = 4'h0;
    on_m = on_m & ~4'h9;
    check("expired", 8'(fet_drive_o), 8'(on_m));
    check("event low", {7'h0, event_oe_o}, 8'h01);
    // host reads the events, then clears them with pushbutton bit 7
    u_host.read_reg(dev, `REG_EVENT_STATUS, rd);
    check("timeout events", rd, 8'h81);
    u_host.write_reg(dev, `REG_PUSHBUTTON, 8'h80, ack);
    cyc(5);
    check("released", {7'h0, event_oe_o}, 8'h00);
    u_host.read_reg(dev, `REG_EVENT_STATUS, rd);
    check("cleared", rd, 8'h00);
    // all ports back on; midspan strap moves before the resets
    u_host.write_reg(dev, `REG_POWER_ON, 8'h0f, ack);
    midspan_strap_i = 1'b1;
    // short chip reset ignored, long one resets registers, ports off
    chip_reset_n_i = 1'b0;
    cyc(10);
    chip_reset_n_i = 1'b1;
    cyc(30);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("rst glitch", rd, 8'(mask_m));
    check("glitch ports", 8'(fet_drive_o), 8'h0f);
    u_host.read_reg(dev, `REG_MODE_LATCH, rd);
    check("mid held", rd, 8'h01);
    chip_reset_n_i = 1'b0;
    cyc(40);
    check("rst ports", 8'(fet_drive_o), 8'h00);
    chip_reset_n_i = 1'b1;
    cyc(10);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("rst mask", rd, `EVENT_MASK_RESET);
    check("rst defaults", 8'(fet_drive_o), 8'(`POWER_ON_AUTO));
    u_host.read_reg(dev, `REG_MODE_LATCH, rd);
    check("mid latched", rd, 8'h03);
    // reset-all bit acts like the chip reset
    u_host.write_reg(dev, `REG_EVENT_MASK, 8'hff, ack);
    u_host.write_reg(dev, `REG_PUSHBUTTON, 8'h10, ack);
    cyc(5);
    u_host.read_reg(dev, `REG_EVENT_MASK, rd);
    check("reset all", rd, `EVENT_MASK_RESET);
    summarize();
  end
endmodule
`default_nettype wire
